// [rtl/rxcfg_pkg.sv]
// Package: register map, field layout and encodings of the receive config bank
package rxcfg_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  CARD_CFG_INDEX   = 8'h1b;
   localparam logic [7:0]  READER_CFG_INDEX = 8'h1c;
   localparam logic [9:0]  CARD_CFG_ADDR    = {CARD_CFG_INDEX, 2'b00};
   localparam logic [9:0]  READER_CFG_ADDR  = {READER_CFG_INDEX, 2'b00};
   localparam int          ADDR_WIDTH       = 10;
   // Card-mode field positions
   localparam int          FRAMING_LSB      = 29;
   localparam int          TAPSEL_LSB       = 26;
   localparam int          EDGE_TH_LSB      = 13;
   localparam int          BIT_TH_LSB       = 0;
   localparam logic [31:0] CARD_WMASK       = 32'h7fffffff;
   localparam logic [31:0] CARD_RESET       = 32'h00000000;
   // Reader-mode field positions
   localparam int          IQSEL_LSB        = 21;
   localparam int          TESTFILT_BIT     = 20;
   localparam int          RESYNC_BIT       = 19;
   localparam int          CORRRST_BIT      = 18;
   localparam int          FILTDIS_BIT      = 17;
   localparam int          EARLY_BIT        = 16;
   localparam logic [31:0] READER_WMASK     = 32'h00ff0000;
   // Resync on by default, correlator reset left off as printed value
   localparam logic [31:0] READER_RESET     = 32'h00080000;
   localparam logic [1:0]  AXI_OKAY         = 2'b00;
   localparam logic [1:0]  AXI_SLVERR       = 2'b10;

   typedef enum logic [1:0] {
      RXCFG_FRAME_A   = 2'b00,
      RXCFG_FRAME_NFC = 2'b01,
      RXCFG_FRAME_JIS = 2'b10,
      RXCFG_FRAME_B   = 2'b11
   } rxcfg_framing_t;

   typedef enum logic [2:0] {
      RXCFG_IQ_BOTH  = 3'b000,
      RXCFG_IQ_I     = 3'b001,
      RXCFG_IQ_Q     = 3'b010,
      RXCFG_IQ_STRONG = 3'b100,
      RXCFG_IQ_FIRST = 3'b101
   } rxcfg_iq_t;
endpackage

// [rtl/rxcfg_tap_decode.sv]
// Module: edge-detector tap count decode
`timescale 1ns/1ps
module rxcfg_tap_decode (
   input  wire logic [2:0] tapCode,
   output logic      [5:0] tapCount
);
   // Codes 110b and 111b share one printed label; 110b taken as 24
   always_comb begin
      case (tapCode)
         3'h0:    tapCount = 6'h04;
         3'h1:    tapCount = 6'h06;
         3'h2:    tapCount = 6'h08;
         3'h3:    tapCount = 6'h08;
         3'h4:    tapCount = 6'h10;
         3'h5:    tapCount = 6'h12;
         3'h6:    tapCount = 6'h18;
         default: tapCount = 6'h20;
      endcase
   end
endmodule // rxcfg_tap_decode

// [rtl/rxcfg_iq_decode.sv]
// Module: BPSK channel selection decode
`timescale 1ns/1ps
module rxcfg_iq_decode (
   input  wire logic [2:0] iqCode,
   output logic            useI,
   output logic            useQ,
   output logic            useStrongest,
   output logic            useFirst,
   output logic            iqReserved
);
   // One-hot steering except the both-channel code; reserved codes fall back to both channels
   always_comb begin
      useI         = 1'b0;
      useQ         = 1'b0;
      useStrongest = 1'b0;
      useFirst     = 1'b0;
      iqReserved   = 1'b0;
      case (iqCode)
         rxcfg_pkg::RXCFG_IQ_BOTH: begin
            useI = 1'b1;
            useQ = 1'b1;
         end
         rxcfg_pkg::RXCFG_IQ_I: begin
            useI = 1'b1;
         end
         rxcfg_pkg::RXCFG_IQ_Q: begin
            useQ = 1'b1;
         end
         rxcfg_pkg::RXCFG_IQ_STRONG: begin
            useStrongest = 1'b1;
         end
         rxcfg_pkg::RXCFG_IQ_FIRST: begin
            useFirst = 1'b1;
         end
         default: begin
            iqReserved = 1'b1;
            useI       = 1'b1;
            useQ       = 1'b1;
         end
      endcase
   end
endmodule // rxcfg_iq_decode

// [rtl/rxcfg_bank.sv]
// Module: receive signal processor configuration bank with AXI4-Lite slave
// Behaviour
// - card framing from bits 30:29
// - mode detector writes framing when auto enabled
// - edge filter taps from bits 28:26
// - edge decision threshold in bits 25:13
// - bit decision threshold in bits 12:0
// - BPSK channel select from bits 23:21
// - bit 19 enables SOF equal resync
// - bit 18 resets correlator on reset
// - bit 17 chooses pattern filter bypass
// - bit 16 accepts data before SOF minimum
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rxcfg_bank (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // AXI4-Lite write address
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Mode detector, same clock domain
   input  wire logic        autoModeEnable,
   input  wire logic        modeDetected,
   input  wire logic [1:0]  detectedFraming,
   // Receiver event from the demodulator, same clock domain
   input  wire logic        rxResetEvent,
   // Card-mode controls
   output logic      [1:0]  cardFraming,
   output logic      [5:0]  edgeFilterTaps,
   output logic      [12:0] edgeDecisionThreshold,
   output logic      [12:0] bitDecisionThreshold,
   // Reader-mode controls
   output logic             bpskUseI,
   output logic             bpskUseQ,
   output logic             bpskUseStrongest,
   output logic             bpskUseFirst,
   output logic             testFilterBit,
   output logic             sofEqualResyncEnable,
   output logic             correlatorReset,
   output logic             patternFilterEnable,
   output logic             earlyDataAccept
);
   logic [31:0] cardCfg_reg;
   logic [31:0] readerCfg_reg;
   logic [9:0]  awAddr_reg;
   logic        awHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0]  wStrb_reg;
   logic        wHeld_reg;
   logic [31:0] strbMask;
   logic        doWrite;
   logic        hitCard;
   logic        hitReader;
   logic [5:0]  tapCount;
   logic        useI;
   logic        useQ;
   logic        useStrongest;
   logic        useFirst;
   logic        iqReserved;
   logic [31:0] readData_next;
   logic [1:0]  readResp_next;

   // Byte lanes widened to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign strbMask[gi*8 +: 8] = {8{wStrb_reg[gi]}};
      end
   endgenerate

   // Address and data may arrive in either order; both held until used
   assign doWrite   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign hitCard   = (awAddr_reg == rxcfg_pkg::CARD_CFG_ADDR);
   assign hitReader = (awAddr_reg == rxcfg_pkg::READER_CFG_ADDR);

   // Write address capture; ready only while no address is held
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         awHeld_reg    <= 1'b0;
         awAddr_reg    <= 10'h000;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_reg <= 1'b0;
         end
      end
   end

   // Write data capture
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wHeld_reg    <= 1'b0;
         wData_reg    <= 32'h00000000;
         wStrb_reg    <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_reg <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rxcfg_pkg::AXI_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (hitCard || hitReader) ? rxcfg_pkg::AXI_OKAY
                                                : rxcfg_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Card-mode register; detector update wins over a software write
   // because it reflects the link actually seen on air
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cardCfg_reg <= rxcfg_pkg::CARD_RESET;
      end else begin
         if (doWrite && hitCard) begin
            cardCfg_reg <= (cardCfg_reg & ~(strbMask & rxcfg_pkg::CARD_WMASK))
               | (wData_reg & strbMask & rxcfg_pkg::CARD_WMASK);
         end
         if (autoModeEnable && modeDetected) begin
            cardCfg_reg[rxcfg_pkg::FRAMING_LSB +: 2] <=
               detectedFraming;
         end
      end
   end

   // Reader-mode register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         readerCfg_reg <= rxcfg_pkg::READER_RESET;
      end else if (doWrite && hitReader) begin
         readerCfg_reg <= (readerCfg_reg
            & ~(strbMask & rxcfg_pkg::READER_WMASK))
            | (wData_reg & strbMask & rxcfg_pkg::READER_WMASK);
      end
   end

   // Read decode
   always_comb begin
      readData_next = 32'h00000000;
      readResp_next = rxcfg_pkg::AXI_OKAY;
      if (s_axi_araddr == rxcfg_pkg::CARD_CFG_ADDR) begin
         readData_next = cardCfg_reg & rxcfg_pkg::CARD_WMASK;
      end else if (s_axi_araddr == rxcfg_pkg::READER_CFG_ADDR) begin
         readData_next = readerCfg_reg & rxcfg_pkg::READER_WMASK;
      end else begin
         readResp_next = rxcfg_pkg::AXI_SLVERR;
      end
   end

   // Read channel: one beat, answer one cycle after address taken
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= rxcfg_pkg::AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readData_next;
            s_axi_rresp  <= readResp_next;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   rxcfg_tap_decode rxcfg_tap_decode_i (
      .tapCode  (cardCfg_reg[rxcfg_pkg::TAPSEL_LSB +: 3]),
      .tapCount (tapCount)
   );

   rxcfg_iq_decode rxcfg_iq_decode_i (
      .iqCode       (readerCfg_reg[rxcfg_pkg::IQSEL_LSB +: 3]),
      .useI         (useI),
      .useQ         (useQ),
      .useStrongest (useStrongest),
      .useFirst     (useFirst),
      .iqReserved   (iqReserved)
   );

   // Registered control outputs towards the demodulator
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cardFraming           <= 2'b00;
         edgeFilterTaps        <= 6'h04;
         edgeDecisionThreshold <= 13'h0000;
         bitDecisionThreshold  <= 13'h0000;
      end else begin
         cardFraming <= cardCfg_reg[rxcfg_pkg::FRAMING_LSB +: 2];
         edgeFilterTaps <= tapCount;
         edgeDecisionThreshold <=
            cardCfg_reg[rxcfg_pkg::EDGE_TH_LSB +: 13];
         bitDecisionThreshold <=
            cardCfg_reg[rxcfg_pkg::BIT_TH_LSB +: 13];
      end
   end

   // Reader-mode outputs; reserved channel codes behave as both channels
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bpskUseI             <= 1'b1;
         bpskUseQ             <= 1'b1;
         bpskUseStrongest     <= 1'b0;
         bpskUseFirst         <= 1'b0;
         testFilterBit        <= 1'b0;
         sofEqualResyncEnable <= 1'b1;
         correlatorReset      <= 1'b0;
         patternFilterEnable  <= 1'b1;
         earlyDataAccept      <= 1'b0;
      end else begin
         bpskUseI         <= useI;
         bpskUseQ         <= useQ;
         bpskUseStrongest <= useStrongest;
         bpskUseFirst     <= useFirst;
         testFilterBit    <= readerCfg_reg[rxcfg_pkg::TESTFILT_BIT];
         sofEqualResyncEnable <=
            readerCfg_reg[rxcfg_pkg::RESYNC_BIT];
         correlatorReset <= readerCfg_reg[rxcfg_pkg::CORRRST_BIT]
                            && rxResetEvent;
         patternFilterEnable <=
            !readerCfg_reg[rxcfg_pkg::FILTDIS_BIT];
         earlyDataAccept <= readerCfg_reg[rxcfg_pkg::EARLY_BIT];
      end
   end

   // Checks; outputs lag the register by one edge, hence the $past terms
   framing_follows_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      autoModeEnable && modeDetected |-> ##2
         cardFraming == $past(detectedFraming, 2))
      else $error("framing not taken from detector");
   detector_wins_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      autoModeEnable && modeDetected |=>
         cardCfg_reg[30:29] == $past(detectedFraming))
      else $error("detector framing lost to a write");
   framing_out_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      ##1 cardFraming == $past(cardCfg_reg[30:29]))
      else $error("framing output mismatch");
   taps_zero_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      cardCfg_reg[28:26] == 3'h0 |=> edgeFilterTaps == 6'h04)
      else $error("tap count wrong");
   taps_top_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      cardCfg_reg[28:26] == 3'h7 |=> edgeFilterTaps == 6'h20)
      else $error("top tap count wrong");
   edge_th_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      $changed(cardCfg_reg[25:13]) |=>
         edgeDecisionThreshold == $past(cardCfg_reg[25:13]))
      else $error("edge threshold stale");
   bit_th_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      $changed(cardCfg_reg[12:0]) |=>
         bitDecisionThreshold == $past(cardCfg_reg[12:0]))
      else $error("bit threshold stale");
   iq_only_i_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      readerCfg_reg[23:21] == 3'h1 |=> bpskUseI && !bpskUseQ)
      else $error("I only select wrong");
   iq_reserved_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      iqReserved |=> bpskUseI && bpskUseQ && !bpskUseStrongest)
      else $error("reserved channel code not both channels");
   resync_enable_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      ##1 sofEqualResyncEnable == $past(readerCfg_reg[19]))
      else $error("resync enable mismatch");
   corr_rst_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      correlatorReset |-> $past(readerCfg_reg[18]) && $past(rxResetEvent))
      else $error("spurious correlator reset");
   corr_rst_on_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      readerCfg_reg[18] && rxResetEvent |=> correlatorReset)
      else $error("correlator reset missed");
   filt_off_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      readerCfg_reg[17] |=> !patternFilterEnable)
      else $error("pattern filter not bypassed");
   early_accept_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      ##1 earlyDataAccept == $past(readerCfg_reg[16]))
      else $error("early accept mismatch");
   rsvd_card_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      s_axi_arvalid && s_axi_arready
         && s_axi_araddr == rxcfg_pkg::CARD_CFG_ADDR |=> !s_axi_rdata[31])
      else $error("card reserved bit read nonzero");
   rsvd_zero_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      s_axi_arvalid && s_axi_arready
         && s_axi_araddr == rxcfg_pkg::READER_CFG_ADDR |=>
         (s_axi_rdata & 32'hff00ffff) == 32'h00000000)
      else $error("reader reserved bits read nonzero");
   rsvd_kept_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      !cardCfg_reg[31] && (readerCfg_reg & 32'hff00ffff) == 32'h00000000)
      else $error("reserved register bits set");
   rd_answer_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   // Main scenarios reached
   wr_card_c: cover property (@(posedge ref_clk) doWrite && hitCard);
   wr_reader_c: cover property (@(posedge ref_clk) doWrite && hitReader);
   auto_mode_c: cover property (@(posedge ref_clk)
      autoModeEnable && modeDetected);
   bad_addr_c: cover property (@(posedge ref_clk)
      s_axi_bvalid && s_axi_bresp == rxcfg_pkg::AXI_SLVERR);
   corr_pulse_c: cover property (@(posedge ref_clk) correlatorReset);
endmodule // rxcfg_bank

// [verif/tb_top.sv]
// Self-checking testbench for the receive configuration bank
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk;
   logic        reset;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, q, cardVal, fr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, detectedFraming, cardFraming, r, f;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, autoModeEnable, modeDetected;
   logic        rxResetEvent, bpskUseI, bpskUseQ, bpskUseStrongest;
   logic        bpskUseFirst, testFilterBit, sofEqualResyncEnable;
   logic        correlatorReset, patternFilterEnable, earlyDataAccept;
   logic [5:0]  edgeFilterTaps;
   logic [12:0] edgeDecisionThreshold, bitDecisionThreshold;
   logic [3:0]  iqSeen;
   logic [9:0]  badAddr [2] = '{10'h000, 10'h074};
   int          errCount = 0;
   int          compares = 0;
   int          seed = 32'h999f;

   // Channel flags packed as {I, Q, strongest, first}
   assign iqSeen = {bpskUseI, bpskUseQ, bpskUseStrongest, bpskUseFirst};

   rxcfg_bank rxcfg_bank_i (
      .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .autoModeEnable, .modeDetected,
      .detectedFraming, .rxResetEvent, .cardFraming, .edgeFilterTaps,
      .edgeDecisionThreshold, .bitDecisionThreshold, .bpskUseI, .bpskUseQ,
      .bpskUseStrongest, .bpskUseFirst, .testFilterBit,
      .sofEqualResyncEnable, .correlatorReset, .patternFilterEnable,
      .earlyDataAccept
   );

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Expected tap count for each filter code
   function automatic logic [31:0] tapExp(input logic [2:0] c);
      case (c)
         3'd0: return 32'd4;
         3'd1: return 32'd6;
         3'd2, 3'd3: return 32'd8;
         3'd4: return 32'd16;
         3'd5: return 32'd18;
         3'd6: return 32'd24;
         default: return 32'd32;
      endcase
   endfunction

   // Expected {I, Q, strongest, first}; reserved codes fall back to both
   function automatic logic [31:0] iqExp(input logic [2:0] c);
      case (c)
         3'b001: return 32'h8;
         3'b010: return 32'h4;
         3'b100: return 32'h2;
         3'b101: return 32'h1;
         default: return 32'hc;
      endcase
   endfunction

   // Single comparison point; case inequality so unknowns never match
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finishTest;
      $display("Counts: %0d compares, %0d mismatches", compares, errCount);
      if (errCount == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One write; address and data offered together, each dropped when taken
   task automatic axiWrite(input logic [9:0] a, input logic [31:0] wd,
                           input logic [3:0] strb, output logic [1:0] resp);
      logic done = 1'b0;
      resp = 2'b11;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= wd;
      s_axi_wstrb <= strb;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // No limit of its own; a hang is ended by the watchdog
      while (!done) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp;
            done = 1'b1;
            s_axi_bready <= 1'b0;
         end
      end
      @(posedge ref_clk);
   endtask

   // One read; extra edge at the end keeps strobes from toggling twice
   task automatic axiRead(input logic [9:0] a, output logic [31:0] rd,
                          output logic [1:0] resp);
      logic done = 1'b0;
      rd = 32'h0;
      resp = 2'b11;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            done = 1'b1;
            s_axi_rready <= 1'b0;
         end
      end
      @(posedge ref_clk);
   endtask

   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, autoModeEnable, modeDetected} = '0;
      {detectedFraming, rxResetEvent} = '0;
      reset = 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      axiRead(rxcfg_pkg::CARD_CFG_ADDR, q, r);
      check(q, 32'h0);
      axiRead(rxcfg_pkg::READER_CFG_ADDR, q, r);
      check(q, 32'h00080000);
      check(edgeFilterTaps, 32'd4);
      check(iqSeen, 32'hc);
      check({sofEqualResyncEnable, patternFilterEnable}, 32'h3);
      $display("test reset done");
      // Every framing and tap code, plus all-ones and all-zeros corners
      for (int i = 0; i < 10; i++) begin
         d = $random(seed);
         d[28:26] = i[2:0];
         d[30:29] = i[1:0];
         if (i == 8) d = 32'hffffffff;
         if (i == 9) d = 32'h0;
         axiWrite(rxcfg_pkg::CARD_CFG_ADDR, d, 4'hf, r);
         check(r, rxcfg_pkg::AXI_OKAY);
         axiRead(rxcfg_pkg::CARD_CFG_ADDR, q, r);
         check(q, d & rxcfg_pkg::CARD_WMASK);
         check(cardFraming, d[30:29]);
         check(edgeFilterTaps, tapExp(d[28:26]));
         check(edgeDecisionThreshold, d[25:13]);
         check(bitDecisionThreshold, d[12:0]);
      end
      // Partial strobes touch only the selected lanes
      axiWrite(rxcfg_pkg::CARD_CFG_ADDR, 32'h12345678, 4'h3, r);
      cardVal = 32'h00005678;
      axiRead(rxcfg_pkg::CARD_CFG_ADDR, q, r);
      check(q, cardVal);
      $display("test card mode done");
      // Every channel code, reserved ones included
      for (int i = 0; i < 10; i++) begin
         d = $random(seed);
         d[23:21] = i[2:0];
         if (i == 8) d = 32'hffffffff;
         if (i == 9) d = 32'h0;
         axiWrite(rxcfg_pkg::READER_CFG_ADDR, d, 4'hf, r);
         axiRead(rxcfg_pkg::READER_CFG_ADDR, q, r);
         check(q, d & rxcfg_pkg::READER_WMASK);
         check(iqSeen, iqExp(d[23:21]));
         check(sofEqualResyncEnable, d[19]);
         check(patternFilterEnable, !d[17]);
         check(earlyDataAccept, d[16]);
         check(correlatorReset, 32'h0);
         check(testFilterBit, d[20]);
      end
      // Correlator reset pulse only when enabled, and one cycle long
      for (int j = 0; j < 2; j++) begin
         axiWrite(rxcfg_pkg::READER_CFG_ADDR, j ? 32'h00040000 : 32'h0,
                  4'hf, r);
         rxResetEvent <= 1'b1;
         @(posedge ref_clk);
         rxResetEvent <= 1'b0;
         @(posedge ref_clk);
         check(correlatorReset, j);
         @(posedge ref_clk);
         check(correlatorReset, 32'h0);
      end
      $display("test reader mode done");
      // Detector updates framing only while enabled; always a new value
      for (int j = 0; j < 4; j++) begin
         fr = $random(seed);
         f = cardVal[30:29] + 2'd1 + {1'b0, fr[0]};
         autoModeEnable <= (j != 1);
         modeDetected <= 1'b1;
         detectedFraming <= f;
         @(posedge ref_clk);
         modeDetected <= 1'b0;
         repeat (2) @(posedge ref_clk);
         if (j != 1) cardVal[30:29] = f;
         check(cardFraming, cardVal[30:29]);
         axiRead(rxcfg_pkg::CARD_CFG_ADDR, q, r);
         check(q, cardVal);
      end
      autoModeEnable <= 1'b0;
      $display("test mode detector done");
      // Unmapped places refuse, and leave the bank untouched
      foreach (badAddr[k]) begin
         axiWrite(badAddr[k], $random(seed), 4'hf, r);
         check(r, rxcfg_pkg::AXI_SLVERR);
         axiRead(badAddr[k], q, r);
         check(q, 32'h0);
         check(r, rxcfg_pkg::AXI_SLVERR);
      end
      axiRead(rxcfg_pkg::CARD_CFG_ADDR, q, r);
      check(q, cardVal);
      $display("test unmapped done");
      finishTest();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      errCount++;
      finishTest();
   end
endmodule // tb_top
